// ===== oneshot_pkg.sv
// shared constants for the software-start one-shot timer
package oneshot_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    // register offsets
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] PERIOD_ADDR = 4'h1;
    localparam logic [3:0] WIDTH_ADDR = 4'h2;
    localparam logic [3:0] COUNT_ADDR = 4'h3;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    // control field layout
    localparam int RUN_BIT = 7;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 5;
    localparam logic [4:0] MODE_ONESHOT_SW = 5'h08;
    // reset values
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] WIDTH_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // status bit positions
    localparam int ST_DRIVE_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    // timer tick divider default
    localparam int TICK_DIV = 1;
endpackage

// ===== tick_divider.sv
// tick enable generator for the timer clock
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_state_type;

    div_state_type s_q;
    div_state_type s_d;

    localparam logic [15:0] LAST = 16'(DIV - 1);

    // one-cycle pulse every DIV clocks; DIV of one means every clock
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= LAST) begin
            s_d.cnt = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// ===== oneshot_timer.sv
// software-start one-shot timer with pwm drive and register port
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module oneshot_timer
    import oneshot_pkg::*;
#(
    parameter int DIV = oneshot_pkg::TICK_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [oneshot_pkg::ADDR_W-1:0] addr,
    input wire logic [oneshot_pkg::DATA_W-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [oneshot_pkg::DATA_W-1:0] rdData,
    output logic pwmDrive,
    output logic running
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] period;
        logic [7:0] width;
        logic [7:0] count;
        logic drive;
        logic done;
        logic [7:0] rdData;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic tick;

    // timer clock enable
    tick_divider #(.DIV(DIV)) tick_divider_i (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    function automatic logic mode_ok(input logic [7:0] c);
        return c[MODE_LSB +: MODE_W] == MODE_ONESHOT_SW;
    endfunction

    // register writes, counting, match handling and read data
    always_comb begin
        logic setRun;
        setRun = 1'b0;
        s_d = s_q;
        s_d.rdData = 8'h00;
        if (wrStb) begin
            unique case (addr)
                CTRL_ADDR: begin
                    // set of run with done up starts a fresh cycle; from a pause it only resumes
                    setRun = wrData[RUN_BIT] && !s_q.ctrl[RUN_BIT];
                    s_d.ctrl = wrData;
                end
                PERIOD_ADDR: s_d.period = wrData;
                WIDTH_ADDR: s_d.width = wrData;
                default: ;
            endcase
        end
        if (setRun && mode_ok(s_d.ctrl) && s_q.done) begin
            s_d.drive = 1'b1;
            s_d.done = 1'b0;
        end
        // pause stretches timing
        // the count follows run as it stood before the edge, so the edge of a
        // clearing write still counts and a pause costs exactly the cycles that
        // run is low; gating on the new run value would move the lost cycles one edge earlier, not add one
        if (tick && s_q.ctrl[RUN_BIT] && mode_ok(s_q.ctrl)) begin
            if (s_q.count == s_q.period) begin
                s_d.count = 8'h00;
                s_d.ctrl[RUN_BIT] = 1'b0;
                s_d.done = 1'b1;
                s_d.drive = 1'b0;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
            if (s_q.count == s_q.width) begin
                s_d.drive = 1'b0;
            end
        end
        if (s_d.done) begin
            s_d.drive = 1'b0;
        end
        if (rdStb) begin
            unique case (addr)
                CTRL_ADDR: s_d.rdData = s_q.ctrl;
                PERIOD_ADDR: s_d.rdData = s_q.period;
                WIDTH_ADDR: s_d.rdData = s_q.width;
                COUNT_ADDR: s_d.rdData = s_q.count;
                STATUS_ADDR: begin
                    s_d.rdData[ST_DRIVE_BIT] = s_q.drive;
                    s_d.rdData[ST_RUN_BIT] = s_q.ctrl[RUN_BIT];
                    s_d.rdData[ST_DONE_BIT] = s_q.done;
                end
                default: s_d.rdData = 8'h00;
            endcase
        end
    end

    // done starts high so the first set of run opens a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.ctrl <= CTRL_RST;
            s_q.period <= PERIOD_RST;
            s_q.width <= WIDTH_RST;
            s_q.count <= 8'h00;
            s_q.drive <= 1'b0;
            s_q.done <= 1'b1;
            s_q.rdData <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;
    assign pwmDrive = s_q.drive;
    assign running = s_q.ctrl[RUN_BIT];

    a_period_match_end: assert property (@(posedge clk) disable iff (rst)
        (tick && running && mode_ok(s_q.ctrl) && s_q.count == s_q.period && !wrStb)
        |=> (!running && s_q.count == 8'h00))
        else $error("period match did not end cycle");

    a_no_self_restart: assert property (@(posedge clk) disable iff (rst)
        (!running && !wrStb) |=> !running)
        else $error("run bit set without software");

    a_pause_holds: assert property (@(posedge clk) disable iff (rst)
        (!running && !(wrStb && addr == CTRL_ADDR)) |=> $stable(s_q.count))
        else $error("count moved while paused");

    a_drive_starts: assert property (@(posedge clk) disable iff (rst)
        (wrStb && addr == CTRL_ADDR && wrData[RUN_BIT] && !running && s_q.done
         && wrData[4:0] == MODE_ONESHOT_SW) |=> pwmDrive)
        else $error("drive did not start with run");

    a_width_drop: assert property (@(posedge clk) disable iff (rst)
        (tick && running && mode_ok(s_q.ctrl) && s_q.count == s_q.width && !wrStb)
        |=> !pwmDrive)
        else $error("drive stayed after width match");

    a_done_no_drive: assert property (@(posedge clk) disable iff (rst)
        s_q.done |-> !pwmDrive)
        else $error("drive active after cycle end");

    a_paused_drive: assert property (@(posedge clk) disable iff (rst)
        (pwmDrive && !running && !wrStb) |=> pwmDrive)
        else $error("drive dropped during pause");

    a_count_step: assert property (@(posedge clk) disable iff (rst)
        (tick && running && mode_ok(s_q.ctrl) && s_q.count != s_q.period && !wrStb)
        |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step");

    a_match_done: assert property (@(posedge clk) disable iff (rst)
        (tick && running && mode_ok(s_q.ctrl) && s_q.count == s_q.period)
        |=> (s_q.done && !pwmDrive))
        else $error("period match did not close cycle");

    a_mode_gate: assert property (@(posedge clk) disable iff (rst)
        (running && !mode_ok(s_q.ctrl)) |=> $stable(s_q.count))
        else $error("count moved outside one-shot mode");

    a_resume_keeps: assert property (@(posedge clk) disable iff (rst)
        (wrStb && addr == CTRL_ADDR && wrData[RUN_BIT] && !running && !s_q.done)
        |=> $stable(s_q.count))
        else $error("resume disturbed the count");

    a_resume_no_drive: assert property (@(posedge clk) disable iff (rst)
        (wrStb && addr == CTRL_ADDR && wrData[RUN_BIT] && !running && !s_q.done)
        |=> (pwmDrive == $past(pwmDrive) && !s_q.done))
        else $error("resume opened a new cycle");

    a_pause_no_end: assert property (@(posedge clk) disable iff (rst)
        (!running && !wrStb) |=> $stable(s_q.done))
        else $error("cycle ended while paused");

    a_drive_needs_write: assert property (@(posedge clk) disable iff (rst)
        (!pwmDrive && !(wrStb && addr == CTRL_ADDR)) |=> !pwmDrive)
        else $error("drive rose without software");

    a_drive_with_run: assert property (@(posedge clk) disable iff (rst)
        $rose(pwmDrive) |-> $rose(running))
        else $error("drive rose apart from run");
endmodule

// ===== timer_one_shot_soft_start_tb.sv
// self-checking bench for the software-start one-shot timer
`timescale 1ns/1ps
module timer_one_shot_soft_start_tb;
    import oneshot_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wrData = 8'h00;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [7:0] rdData;
    logic pwmDrive;
    logic running;
    int errTotal = 0;
    int totalChecks = 0;
    int d0, t0, d1, t1;
    logic [7:0] v;
    oneshot_timer #(.DIV(1)) oneshot_timer_i (.clk(clk), .rst(rst), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .pwmDrive(pwmDrive), .running(running));
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask
    // one full cycle, optional pause written at loop step pAt for pLen cycles;
    // drv counts cycles with drive up, tot cycles until run drops at the match
    task automatic shot(input int pAt, input int pLen, output int drv, output int tot);
        logic stb;
        wr(CTRL_ADDR, 8'h88);
        #1;
        // drive starts with run
        chk({7'h00, pwmDrive}, 8'h01);
        drv = 1;
        tot = 1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            // one strobe assignment per edge: pause at pAt, resume pLen later
            stb = pLen > 0 && (i == pAt || i == pAt + pLen);
            addr <= CTRL_ADDR;
            wrData <= (i == pAt) ? 8'h08 : 8'h88;
            wrStb <= stb;
            // outputs are read once they have settled after the edge
            #1;
            if (running !== 1'b1 && i > pAt + pLen + 2) break;
            drv += int'(pwmDrive);
            tot++;
        end
        rd(COUNT_ADDR, v);
        chk(v, 8'h00);
        chk({7'h00, pwmDrive}, 8'h00);
    endtask
    task automatic test_reset();
        rd(PERIOD_ADDR, v);
        chk(v, PERIOD_RST);
        rd(WIDTH_ADDR, v);
        chk(v, WIDTH_RST);
        rd(CTRL_ADDR, v);
        chk(v, CTRL_RST);
        // only done is up after reset: drive off, run clear
        rd(STATUS_ADDR, v);
        chk(v, 8'h04);
        // the count is read-only, only ticks may move it
        wr(COUNT_ADDR, 8'h33);
        rd(COUNT_ADDR, v);
        chk(v, 8'h00);
        rd(4'hF, v);
        chk(v, 8'h00);
        $display("test_reset done");
    endtask
    // counter holds when run is set with another mode
    task automatic test_mode();
        wr(CTRL_ADDR, 8'h80);
        repeat (6) @(posedge clk);
        rd(COUNT_ADDR, v);
        chk(v, 8'h00);
        chk({7'h00, pwmDrive}, 8'h00);
        wr(CTRL_ADDR, 8'h00);
        $display("test_mode done");
    endtask
    task automatic test_shots();
        wr(PERIOD_ADDR, 8'h14);
        wr(WIDTH_ADDR, 8'h08);
        shot(0, 0, d0, t0);
        // both compares see the count before it steps: drive lasts width plus
        // one cycles, the run bit period plus one
        chk(8'(d0), 8'h09);
        chk(8'(t0), 8'h15);
        // no self restart after the period match
        repeat (20) @(posedge clk);
        #1;
        chk({7'h00, running}, 8'h00);
        shot(3, 7, d1, t1);
        chk(8'(d1), 8'(d0 + 7));
        chk(8'(t1), 8'(t0 + 7));
        shot(12, 5, d1, t1);
        chk(8'(d1), 8'(d0));
        chk(8'(t1), 8'(t0 + 5));
        wr(WIDTH_ADDR, 8'h0C);
        shot(0, 0, d1, t1);
        chk(8'(d1), 8'(d0 + 4));
        chk(8'(t1), 8'(t0));
        $display("test_shots done");
    endtask
    task automatic closeOut();
        $display("checks=%0d mismatches=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog: the tests need well under 1,000 cycles, 10,000 means a hang
    initial begin
        #200000;
        errTotal++;
        closeOut();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_mode();
        test_shots();
        closeOut();
    end
endmodule
